// ### rtl/aux_timer_pkg.sv
// Constants, register map and field layout of the auxiliary timer reload and capture block
package aux_timer_pkg;
	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_CORE_CTRL = 8'h00;
	localparam logic [7:0] OFF_A_CTRL = 8'h04;
	localparam logic [7:0] OFF_B_CTRL = 8'h08;
	localparam logic [7:0] OFF_CORE_VAL = 8'h0C;
	localparam logic [7:0] OFF_A_VAL = 8'h10;
	localparam logic [7:0] OFF_B_VAL = 8'h14;
	localparam logic [7:0] OFF_CORE_IRQ = 8'h18;
	localparam logic [7:0] OFF_A_IRQ = 8'h1C;
	localparam logic [7:0] OFF_B_IRQ = 8'h20;

	// ------------------------------------------------------------
	// Control register fields
	// ------------------------------------------------------------
	localparam int POS_ISEL = 0;
	localparam int POS_MODE = 3;
	localparam int POS_RUN = 6;
	localparam int POS_UD = 7;
	localparam int POS_UDE = 8;
	localparam int POS_OE = 9;
	localparam int POS_OTL = 10;
	localparam logic [15:0] MASK_AUX_CTRL = 16'h01FF;
	localparam logic [15:0] MASK_CORE_CTRL = 16'h07FF;
	localparam int POS_IRQ_EN = 6;
	localparam int POS_IRQ_FLAG = 7;

	// ------------------------------------------------------------
	// Reset values and encodings
	// ------------------------------------------------------------
	localparam logic [15:0] RST_CTRL = 16'h0000;
	localparam logic [15:0] RST_VAL = 16'h0000;
	localparam logic [15:0] VAL_ALL_ONES = 16'hFFFF;
	localparam logic [2:0] MODE_TIMER = 3'h0;
	localparam logic [2:0] MODE_COUNTER = 3'h1;
	localparam logic [2:0] MODE_GATE_LOW = 3'h2;
	localparam logic [2:0] MODE_GATE_HIGH = 3'h3;
	localparam logic [2:0] MODE_RELOAD = 3'h4;
	localparam logic [2:0] MODE_CAPTURE = 3'h5;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [9:0] PRE_BASE = 10'h004;
	localparam int PRE_W = 10;
	localparam int SYNC_STAGES = 2;
endpackage

// ### rtl/pin_edge_sync.sv
// Two-stage synchroniser and edge finder for the external trigger pins
`timescale 1ns/10ps
module pin_edge_sync #(
	parameter int W = 3
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [W-1:0] pins_in,
	output logic [W-1:0] level_out,
	output logic [W-1:0] rise_out,
	output logic [W-1:0] fall_out
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
		logic [W-1:0] prev;
	} sync_t;

	sync_t s;
	sync_t next_s;

	// Meta stage feeds only the sync stage; edges compare sync against prev
	always_comb begin
		next_s = s;
		next_s.meta = pins_in;
		next_s.sync = s.meta;
		next_s.prev = s.sync;
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// Edge pulses last one cycle each
	assign level_out = s.sync;
	assign rise_out = s.sync & ~s.prev;
	assign fall_out = ~s.sync & s.prev;
endmodule

// ### rtl/aux_timer_reload_capture.sv
// Timer block with core timer, two auxiliary timers, reload, capture and request flags
`timescale 1ns/10ps
module aux_timer_reload_capture #(
	parameter int ADDR_W = 8
) (
	input wire logic CLK_SYS_IN,
	input wire logic RST_N_IN,
	input wire logic [ADDR_W-1:0] AWADDR_IN,
	input wire logic AWVALID_IN,
	output logic AWREADY_OUT,
	input wire logic [31:0] WDATA_IN,
	input wire logic [3:0] WSTRB_IN,
	input wire logic WVALID_IN,
	output logic WREADY_OUT,
	output logic [1:0] BRESP_OUT,
	output logic BVALID_OUT,
	input wire logic BREADY_IN,
	input wire logic [ADDR_W-1:0] ARADDR_IN,
	input wire logic ARVALID_IN,
	output logic ARREADY_OUT,
	output logic [31:0] RDATA_OUT,
	output logic [1:0] RRESP_OUT,
	output logic RVALID_OUT,
	input wire logic RREADY_IN,
	input wire logic CORE_TRIGGER_PIN_IN,
	input wire logic AUX_A_TRIGGER_PIN_IN,
	input wire logic AUX_B_TRIGGER_PIN_IN,
	output logic CORE_TOGGLE_OUTPUT_PIN_OUT,
	output logic CORE_VECTOR_OUT,
	output logic AUX_A_VECTOR_OUT,
	output logic AUX_B_VECTOR_OUT
);
	import aux_timer_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic awready;
		logic wready;
		logic aw_held;
		logic w_held;
		logic [ADDR_W-1:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [15:0] core_ctrl;
		logic [15:0] a_ctrl;
		logic [15:0] b_ctrl;
		logic [15:0] core_val;
		logic [15:0] a_val;
		logic [15:0] b_val;
		logic [2:0] irq_flag;
		logic [2:0] irq_en;
		logic [2:0] vec;
		logic toggle_pin;
		logic [PRE_W-1:0] pre;
	} state_t;

	state_t s;
	state_t next_s;

	logic [2:0] pin_level;
	logic [2:0] pin_rise;
	logic [2:0] pin_fall;

	// ------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------
	// Edge match for a select code; top bit picks latch over pin
	function automatic logic trig_match(input logic [2:0] sel, input logic p_r, input logic p_f,
		input logic l_r, input logic l_f);
		logic r;
		logic f;
		r = sel[2] ? l_r : p_r;
		f = sel[2] ? l_f : p_f;
		trig_match = (sel[0] & r) | (sel[1] & f);
	endfunction

	// Prescaler tick every 4 * 2^sel cycles
	function automatic logic pre_tick(input logic [PRE_W-1:0] cnt, input logic [2:0] sel);
		logic [PRE_W-1:0] mask;
		mask = (PRE_BASE << sel) - PRE_BASE[PRE_W-1:0] / PRE_BASE;
		pre_tick = ((cnt & mask) == mask);
	endfunction

	// Wrap detection for one count step
	function automatic logic wraps(input logic [15:0] v, input logic down);
		wraps = down ? (v == RST_VAL) : (v == VAL_ALL_ONES);
	endfunction

	function automatic logic [15:0] step(input logic [15:0] v, input logic down);
		step = down ? 16'(v - 16'h0001) : 16'(v + 16'h0001);
	endfunction

	// Count enable of a timer in timer, counter or gated mode
	function automatic logic count_en(input logic [15:0] ctrl, input logic [PRE_W-1:0] cnt,
		input logic lvl, input logic p_r, input logic p_f, input logic l_r, input logic l_f);
		logic [2:0] m;
		logic [2:0] sel;
		m = ctrl[POS_MODE+:3];
		sel = ctrl[POS_ISEL+:3];
		case (m)
			MODE_TIMER: count_en = ctrl[POS_RUN] & pre_tick(cnt, sel);
			MODE_COUNTER: count_en = ctrl[POS_RUN] & trig_match(sel, p_r, p_f, l_r, l_f);
			MODE_GATE_LOW: count_en = ctrl[POS_RUN] & ~lvl & pre_tick(cnt, sel);
			MODE_GATE_HIGH: count_en = ctrl[POS_RUN] & lvl & pre_tick(cnt, sel);
			default: count_en = 1'b0;
		endcase
	endfunction

	// Byte-lane merge of the low half word
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] st);
		merge = {st[1] ? d[15:8] : old[15:8], st[0] ? d[7:0] : old[7:0]};
	endfunction

	// ------------------------------------------------------------
	// Trigger pin synchronisers
	// ------------------------------------------------------------
	pin_edge_sync #(
		.W(3)
	) u_pins (
		.clk_in(CLK_SYS_IN),
		.rst_n_in(RST_N_IN),
		.pins_in({AUX_B_TRIGGER_PIN_IN, AUX_A_TRIGGER_PIN_IN, CORE_TRIGGER_PIN_IN}),
		.level_out(pin_level),
		.rise_out(pin_rise),
		.fall_out(pin_fall)
	);

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb begin
		logic core_en;
		logic core_ovf;
		logic tl_r;
		logic tl_f;
		logic a_en;
		logic b_en;
		logic rld_a;
		logic rld_b;
		logic cap_a;
		logic cap_b;
		logic do_write;
		logic [2:0] hw_set;
		logic [2:0] a_sel;
		logic [2:0] b_sel;
		logic [2:0] a_cap_sel;
		logic [2:0] b_cap_sel;
		logic [15:0] w16;
		next_s = s;
		hw_set = 3'h0;
		a_sel = s.a_ctrl[POS_ISEL+:3];
		b_sel = s.b_ctrl[POS_ISEL+:3];
		a_cap_sel = {1'b0, a_sel[1:0]};
		b_cap_sel = {1'b0, b_sel[1:0]};
		w16 = 16'h0000;
		next_s.pre = PRE_W'(s.pre + 1'b1);

		// Core timer count and wrap
		core_en = count_en(s.core_ctrl, s.pre, pin_level[0], pin_rise[0], pin_fall[0], 1'b0, 1'b0);
		core_ovf = core_en & wraps(s.core_val, s.core_ctrl[POS_UD]);
		// Latch transitions derived only from wraps
		tl_r = core_ovf & ~s.core_ctrl[POS_OTL];
		tl_f = core_ovf & s.core_ctrl[POS_OTL];
		if (core_ovf) begin
			next_s.core_ctrl[POS_OTL] = ~s.core_ctrl[POS_OTL];
			hw_set[0] = 1'b1;
		end
		if (core_en) begin
			next_s.core_val = step(s.core_val, s.core_ctrl[POS_UD]);
		end

		// Reload triggers
		rld_a = (s.a_ctrl[POS_MODE+:3] == MODE_RELOAD)
			& trig_match(a_sel, pin_rise[1], pin_fall[1], tl_r, tl_f);
		rld_b = (s.b_ctrl[POS_MODE+:3] == MODE_RELOAD)
			& trig_match(b_sel, pin_rise[2], pin_fall[2], tl_r, tl_f);
		// Later assignment wins, so timer b overrides timer a on a shared event
		if (rld_a) begin
			next_s.core_val = s.a_val;
			hw_set[1] = 1'b1;
		end
		if (rld_b) begin
			next_s.core_val = s.b_val;
			hw_set[2] = 1'b1;
		end

		// Capture events
		cap_a = (s.a_ctrl[POS_MODE+:3] == MODE_CAPTURE)
			& trig_match(a_cap_sel, pin_rise[1], pin_fall[1], 1'b0, 1'b0);
		cap_b = (s.b_ctrl[POS_MODE+:3] == MODE_CAPTURE)
			& trig_match(b_cap_sel, pin_rise[2], pin_fall[2], 1'b0, 1'b0);
		if (cap_a) begin
			next_s.a_val = s.core_val;
			hw_set[1] = 1'b1;
		end
		if (cap_b) begin
			next_s.b_val = s.core_val;
			hw_set[2] = 1'b1;
		end

		// Auxiliary timers count only in counting modes
		a_en = count_en(s.a_ctrl, s.pre, pin_level[1], pin_rise[1], pin_fall[1], tl_r, tl_f);
		b_en = count_en(s.b_ctrl, s.pre, pin_level[2], pin_rise[2], pin_fall[2], tl_r, tl_f);
		if (a_en) begin
			next_s.a_val = step(s.a_val, s.a_ctrl[POS_UD]);
			hw_set[1] = hw_set[1] | wraps(s.a_val, s.a_ctrl[POS_UD]);
		end
		if (b_en) begin
			next_s.b_val = step(s.b_val, s.b_ctrl[POS_UD]);
			hw_set[2] = hw_set[2] | wraps(s.b_val, s.b_ctrl[POS_UD]);
		end

		// Write address and data channels, taken in either order
		if (s.awready && AWVALID_IN) begin
			next_s.awready = 1'b0;
			next_s.aw_held = 1'b1;
			next_s.awaddr = AWADDR_IN;
		end
		if (s.wready && WVALID_IN) begin
			next_s.wready = 1'b0;
			next_s.w_held = 1'b1;
			next_s.wdata = WDATA_IN;
			next_s.wstrb = WSTRB_IN;
		end
		do_write = s.aw_held & s.w_held & ~s.bvalid;
		if (do_write) begin
			next_s.aw_held = 1'b0;
			next_s.w_held = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = RESP_OKAY;
			case (s.awaddr)
				OFF_CORE_CTRL: begin
					// Latch write lands directly, with no trigger side effect
					w16 = merge(s.core_ctrl, s.wdata, s.wstrb) & MASK_CORE_CTRL;
					next_s.core_ctrl = w16;
				end
				OFF_A_CTRL: next_s.a_ctrl = merge(s.a_ctrl, s.wdata, s.wstrb) & MASK_AUX_CTRL;
				OFF_B_CTRL: next_s.b_ctrl = merge(s.b_ctrl, s.wdata, s.wstrb) & MASK_AUX_CTRL;
				OFF_CORE_VAL: next_s.core_val = merge(s.core_val, s.wdata, s.wstrb);
				OFF_A_VAL: next_s.a_val = merge(s.a_val, s.wdata, s.wstrb);
				OFF_B_VAL: next_s.b_val = merge(s.b_val, s.wdata, s.wstrb);
				OFF_CORE_IRQ: begin
					if (s.wstrb[0]) begin
						next_s.irq_flag[0] = s.wdata[POS_IRQ_FLAG];
						next_s.irq_en[0] = s.wdata[POS_IRQ_EN];
					end
				end
				OFF_A_IRQ: begin
					if (s.wstrb[0]) begin
						next_s.irq_flag[1] = s.wdata[POS_IRQ_FLAG];
						next_s.irq_en[1] = s.wdata[POS_IRQ_EN];
					end
				end
				OFF_B_IRQ: begin
					if (s.wstrb[0]) begin
						next_s.irq_flag[2] = s.wdata[POS_IRQ_FLAG];
						next_s.irq_en[2] = s.wdata[POS_IRQ_EN];
					end
				end
				default: next_s.bresp = RESP_SLVERR;
			endcase
		end
		if (s.bvalid && BREADY_IN) begin
			next_s.bvalid = 1'b0;
			next_s.awready = 1'b1;
			next_s.wready = 1'b1;
		end

		// Hardware set beats a software clear in the same cycle
		next_s.irq_flag = next_s.irq_flag | hw_set;
		next_s.vec = next_s.irq_flag & next_s.irq_en;
		next_s.toggle_pin = next_s.core_ctrl[POS_OTL] & next_s.core_ctrl[POS_OE];

		// Read channel, one outstanding read
		if (s.arready && ARVALID_IN) begin
			next_s.arready = 1'b0;
			next_s.rvalid = 1'b1;
			next_s.rresp = RESP_OKAY;
			next_s.rdata = 32'h00000000;
			case (ARADDR_IN)
				OFF_CORE_CTRL: next_s.rdata = {16'h0000, s.core_ctrl};
				OFF_A_CTRL: next_s.rdata = {16'h0000, s.a_ctrl};
				OFF_B_CTRL: next_s.rdata = {16'h0000, s.b_ctrl};
				OFF_CORE_VAL: next_s.rdata = {16'h0000, s.core_val};
				OFF_A_VAL: next_s.rdata = {16'h0000, s.a_val};
				OFF_B_VAL: next_s.rdata = {16'h0000, s.b_val};
				OFF_CORE_IRQ: next_s.rdata = {24'h000000, s.irq_flag[0], s.irq_en[0], 6'h00};
				OFF_A_IRQ: next_s.rdata = {24'h000000, s.irq_flag[1], s.irq_en[1], 6'h00};
				OFF_B_IRQ: next_s.rdata = {24'h000000, s.irq_flag[2], s.irq_en[2], 6'h00};
				default: next_s.rresp = RESP_SLVERR;
			endcase
		end
		if (s.rvalid && RREADY_IN) begin
			next_s.rvalid = 1'b0;
			next_s.arready = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge CLK_SYS_IN) begin
		if (!RST_N_IN) begin
			s <= '0;
			s.awready <= 1'b1;
			s.wready <= 1'b1;
			s.arready <= 1'b1;
			s.core_ctrl <= RST_CTRL;
			s.a_ctrl <= RST_CTRL;
			s.b_ctrl <= RST_CTRL;
			s.core_val <= RST_VAL;
			s.a_val <= RST_VAL;
			s.b_val <= RST_VAL;
		end else begin
			s <= next_s;
		end
	end

	// ------------------------------------------------------------
	// Outputs, all from the state register
	// ------------------------------------------------------------
	assign AWREADY_OUT = s.awready;
	assign WREADY_OUT = s.wready;
	assign BVALID_OUT = s.bvalid;
	assign BRESP_OUT = s.bresp;
	assign ARREADY_OUT = s.arready;
	assign RVALID_OUT = s.rvalid;
	assign RRESP_OUT = s.rresp;
	assign RDATA_OUT = s.rdata;
	assign CORE_TOGGLE_OUTPUT_PIN_OUT = s.toggle_pin;
	assign CORE_VECTOR_OUT = s.vec[0];
	assign AUX_A_VECTOR_OUT = s.vec[1];
	assign AUX_B_VECTOR_OUT = s.vec[2];
endmodule

// ### tb/trigger_pin_model.sv
// External trigger source that drives one trigger input pin
`timescale 1ns/10ps
module trigger_pin_model (
	input wire logic clk_in,
	output logic pin_out
);
	// ------------------------------------------------------------
	// Pin level
	// ------------------------------------------------------------
	initial pin_out = 1'b0;
	// Change level after an edge, then hold it ten cycles
	task automatic drive(input logic lvl);
		@(posedge clk_in);
		pin_out <= lvl;
		repeat (10) @(posedge clk_in);
	endtask
endmodule

// ### tb/aux_timer_assertions.sv
// Handshake and vector assertions for the auxiliary timer block
`timescale 1ns/10ps
module aux_timer_assertions (
	input wire logic CLK_SYS_IN,
	input wire logic RST_N_IN,
	input wire logic AWVALID_IN,
	input wire logic AWREADY_OUT,
	input wire logic WVALID_IN,
	input wire logic WREADY_OUT,
	input wire logic [1:0] BRESP_OUT,
	input wire logic BVALID_OUT,
	input wire logic BREADY_IN,
	input wire logic ARVALID_IN,
	input wire logic ARREADY_OUT,
	input wire logic [31:0] RDATA_OUT,
	input wire logic RVALID_OUT,
	input wire logic RREADY_IN,
	input wire logic CORE_VECTOR_OUT,
	input wire logic AUX_A_VECTOR_OUT,
	input wire logic AUX_B_VECTOR_OUT
);
	default clocking cb @(posedge CLK_SYS_IN); endclocking
	default disable iff (!RST_N_IN);
	// ------------------------------------------------------------
	// Bus steps
	// ------------------------------------------------------------
	sequence wr_taken;
		AWVALID_IN && AWREADY_OUT && WVALID_IN && WREADY_OUT;
	endsequence
	sequence rd_taken;
		ARVALID_IN && ARREADY_OUT;
	endsequence
	sequence wr_done;
		$rose(BVALID_OUT);
	endsequence
	// Answers come at the fixed latency and stand until taken
	chk_write_answer: assert property (wr_taken |=> !BVALID_OUT ##1 BVALID_OUT) else $error("write answer mistimed");
	chk_aw_closed: assert property (wr_taken |=> !AWREADY_OUT && !WREADY_OUT) else $error("write ready not dropped");
	chk_read_answer: assert property (rd_taken |=> RVALID_OUT && !ARREADY_OUT) else $error("read answer mistimed");
	chk_bresp_stand: assert property (BVALID_OUT && !BREADY_IN |=> BVALID_OUT && $stable(BRESP_OUT))
		else $error("write response not held");
	chk_rdata_stand: assert property (RVALID_OUT && !RREADY_IN |=> RVALID_OUT && $stable(RDATA_OUT))
		else $error("read data not held");
	chk_b_release: assert property (BVALID_OUT && BREADY_IN |=> !BVALID_OUT && AWREADY_OUT) else $error("write not released");
	// Sticky flags: a vector only drops at a software write
	chk_core_clear: assert property ($fell(CORE_VECTOR_OUT) |-> wr_done) else $error("core vector dropped");
	chk_a_clear: assert property ($fell(AUX_A_VECTOR_OUT) |-> wr_done) else $error("aux a vector dropped");
	chk_b_clear: assert property ($fell(AUX_B_VECTOR_OUT) |-> wr_done) else $error("aux b vector dropped");
endmodule
bind aux_timer_reload_capture aux_timer_assertions aux_timer_assertions_inst (.CLK_SYS_IN, .RST_N_IN, .AWVALID_IN,
	.AWREADY_OUT, .WVALID_IN, .WREADY_OUT, .BRESP_OUT, .BVALID_OUT, .BREADY_IN, .ARVALID_IN, .ARREADY_OUT,
	.RDATA_OUT, .RVALID_OUT, .RREADY_IN, .CORE_VECTOR_OUT, .AUX_A_VECTOR_OUT, .AUX_B_VECTOR_OUT);

// ### tb/testbench.sv
// Self-checking bench for the auxiliary timer reload and capture block
`timescale 1ns/10ps
module testbench;
	import aux_timer_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h00000000;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	wire logic awready, wready, bvalid, arready, rvalid, tog, vec_c, vec_a, vec_b, pin_a, pin_b, pin_c;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	int bad_count = 0;
	int checks = 0;
	logic [31:0] seed = 32'h00003277;
	logic [31:0] d, c;
	logic [15:0] v, w, e;
	logic [1:0] r;
	// ------------------------------------------------------------
	// Design, pin models and clock
	// ------------------------------------------------------------
	aux_timer_reload_capture aux_timer_reload_capture_inst (.CLK_SYS_IN(clk), .RST_N_IN(rst_n),
		.AWADDR_IN(awaddr), .AWVALID_IN(awvalid), .AWREADY_OUT(awready), .WDATA_IN(wdata), .WSTRB_IN(wstrb),
		.WVALID_IN(wvalid), .WREADY_OUT(wready), .BRESP_OUT(bresp), .BVALID_OUT(bvalid), .BREADY_IN(bready),
		.ARADDR_IN(araddr), .ARVALID_IN(arvalid), .ARREADY_OUT(arready), .RDATA_OUT(rdata), .RRESP_OUT(rresp),
		.RVALID_OUT(rvalid), .RREADY_IN(rready), .CORE_TRIGGER_PIN_IN(pin_c), .AUX_A_TRIGGER_PIN_IN(pin_a),
		.AUX_B_TRIGGER_PIN_IN(pin_b), .CORE_TOGGLE_OUTPUT_PIN_OUT(tog), .CORE_VECTOR_OUT(vec_c),
		.AUX_A_VECTOR_OUT(vec_a), .AUX_B_VECTOR_OUT(vec_b));
	trigger_pin_model pa (.clk_in(clk), .pin_out(pin_a));
	trigger_pin_model pb (.clk_in(clk), .pin_out(pin_b));
	trigger_pin_model pc (.clk_in(clk), .pin_out(pin_c));
	always #4 clk = ~clk;
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [15:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		rnd = seed[15:0];
	endfunction
	function automatic logic [15:0] cw(input logic [2:0] sel, input logic [2:0] mode, input logic run, input logic dn);
		cw = 16'h0000;
		cw[POS_ISEL +: 3] = sel;
		cw[POS_MODE +: 3] = mode;
		cw[POS_RUN] = run;
		cw[POS_UD] = dn;
	endfunction
	function automatic logic [15:0] iw(input logic en, input logic fl);
		iw = 16'h0000;
		iw[POS_IRQ_EN] = en;
		iw[POS_IRQ_FLAG] = fl;
	endfunction
	// Register value after one pin edge in capture mode
	function automatic logic [15:0] cap_exp(input logic [2:0] sel, input logic rise, input logic [15:0] old,
		input logic [15:0] now);
		cap_exp = (rise ? sel[0] : sel[1]) ? now : old;
	endfunction
	task automatic check(input string n, input logic [31:0] ex, input logic [31:0] got);
		checks++;
		if (got !== ex) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, ex, got);
		end
	endtask
	// Write one register; address and data offered together
	// Response ready starts high or low at random, so the answer must also stand while unaccepted
	task automatic bus_wr(input logic [7:0] a, input logic [15:0] dv);
		logic [15:0] q;
		q = rnd();
		@(posedge clk);
		awaddr <= a;
		wdata <= {16'h0000, dv};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= q[0];
		do begin
			@(posedge clk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1 && bready !== 1'b1) bready <= 1'b1;
		end while (bvalid !== 1'b1 || bready !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic bus_rd(input logic [7:0] a);
		logic [15:0] q;
		q = rnd();
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= q[0];
		do begin
			@(posedge clk);
			if (arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1 && rready !== 1'b1) rready <= 1'b1;
		end while (rvalid !== 1'b1 || rready !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex);
		bus_rd(a);
		check($sformatf("register %h", a), ex, d);
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 9; i++) rd_chk(8'(i * 4), RST_VAL);
		bus_rd(8'h24);
		check("read resp", RESP_SLVERR, r);
		bus_wr(8'h24, 16'hFFFF);
		check("write resp", RESP_SLVERR, r);
		bus_wr(OFF_A_CTRL, 16'hFFFF);
		rd_chk(OFF_A_CTRL, MASK_AUX_CTRL);
		$display("test registers done");
		// Capture with top select bit set and run bit high
		v = rnd();
		bus_wr(OFF_CORE_VAL, v);
		bus_wr(OFF_A_IRQ, iw(1'b1, 1'b0));
		bus_wr(OFF_A_CTRL, cw(3'h5, MODE_CAPTURE, 1'b1, 1'b0));
		pa.drive(1'b1);
		rd_chk(OFF_A_VAL, v);
		rd_chk(OFF_A_IRQ, iw(1'b1, 1'b1));
		check("aux a vector", 1, vec_a);
		bus_wr(OFF_CORE_VAL, ~v);
		pa.drive(1'b0);
		rd_chk(OFF_A_VAL, v);
		bus_wr(OFF_A_IRQ, iw(1'b1, 1'b0));
		check("aux a vector", 0, vec_a);
		// Every select code against both pin edges
		e = rnd();
		bus_wr(OFF_B_VAL, e);
		for (int i = 0; i < 8; i++) begin
			bus_wr(OFF_B_CTRL, cw(3'(i), MODE_CAPTURE, 1'b1, 1'b0));
			w = rnd();
			bus_wr(OFF_CORE_VAL, w);
			pb.drive(1'b1);
			e = cap_exp(3'(i), 1'b1, e, w);
			rd_chk(OFF_B_VAL, e);
			w = rnd();
			bus_wr(OFF_CORE_VAL, w);
			pb.drive(1'b0);
			e = cap_exp(3'(i), 1'b0, e, w);
			rd_chk(OFF_B_VAL, e);
		end
		$display("test capture done");
		// Reload from a pin edge
		bus_wr(OFF_B_CTRL, cw(3'h1, MODE_RELOAD, 1'b1, 1'b0));
		bus_wr(OFF_B_IRQ, iw(1'b1, 1'b0));
		v = rnd();
		bus_wr(OFF_B_VAL, v);
		bus_wr(OFF_CORE_VAL, ~v);
		pb.drive(1'b1);
		rd_chk(OFF_CORE_VAL, v);
		rd_chk(OFF_B_VAL, v);
		rd_chk(OFF_B_IRQ, iw(1'b1, 1'b1));
		rd_chk(OFF_CORE_IRQ, 0);
		check("aux b vector", 1, vec_b);
		bus_wr(OFF_B_IRQ, 0);
		$display("test pin reload done");
		// Down count wrap from 0000
		bus_wr(OFF_B_CTRL, 0);
		bus_wr(OFF_CORE_IRQ, iw(1'b1, 1'b0));
		bus_wr(OFF_CORE_VAL, 16'h0001);
		bus_wr(OFF_CORE_CTRL, cw(3'h0, MODE_TIMER, 1'b1, 1'b1));
		repeat (20) @(posedge clk);
		bus_rd(OFF_CORE_VAL);
		check("core top byte", 8'hFF, d[15:8]);
		rd_chk(OFF_CORE_IRQ, iw(1'b1, 1'b1));
		check("core vector", 1, vec_c);
		// Both aux timers on every latch transition
		v = rnd() & 16'hFF00;
		w = ~v & 16'hFF00;
		bus_wr(OFF_A_VAL, w);
		bus_wr(OFF_B_VAL, v);
		bus_wr(OFF_A_CTRL, cw(3'h7, MODE_RELOAD, 1'b0, 1'b0));
		bus_wr(OFF_B_CTRL, cw(3'h7, MODE_RELOAD, 1'b0, 1'b0));
		bus_wr(OFF_CORE_CTRL, cw(3'h0, MODE_TIMER, 1'b1, 1'b0));
		for (int k = 0; k < 2; k++) begin
			bus_wr(OFF_CORE_IRQ, iw(1'b1, 1'b0));
			bus_wr(OFF_CORE_VAL, VAL_ALL_ONES);
			repeat (20) @(posedge clk);
			bus_rd(OFF_CORE_VAL);
			check("core reload", v[15:8], d[15:8]);
			rd_chk(OFF_CORE_IRQ, iw(1'b1, 1'b1));
		end
		// Opposite edges alternate the two sources
		bus_wr(OFF_A_CTRL, cw(3'h5, MODE_RELOAD, 1'b0, 1'b0));
		bus_wr(OFF_B_CTRL, cw(3'h6, MODE_RELOAD, 1'b0, 1'b0));
		for (int k = 0; k < 4; k++) begin
			bus_rd(OFF_CORE_CTRL);
			c = d;
			e = c[POS_OTL] ? v : w;
			bus_wr(OFF_CORE_VAL, VAL_ALL_ONES);
			repeat (20) @(posedge clk);
			bus_rd(OFF_CORE_VAL);
			check("pwm reload", e[15:8], d[15:8]);
		end
		$display("test latch reload done");
		// Software latch writes stay quiet
		bus_wr(OFF_CORE_CTRL, 16'h0000);
		bus_wr(OFF_A_IRQ, 0);
		bus_wr(OFF_B_IRQ, 0);
		bus_wr(OFF_CORE_VAL, 16'h1234);
		bus_wr(OFF_CORE_CTRL, 16'h0600);
		check("toggle pin", 1, tog);
		bus_wr(OFF_CORE_CTRL, 16'h0200);
		check("toggle pin", 0, tog);
		rd_chk(OFF_CORE_VAL, 16'h1234);
		rd_chk(OFF_A_IRQ, 0);
		rd_chk(OFF_B_IRQ, 0);
		// Low byte lane only, then one core count from its own pin
		wstrb <= 4'h1;
		bus_wr(OFF_CORE_VAL, 16'h5678);
		wstrb <= 4'hF;
		rd_chk(OFF_CORE_VAL, 16'h1278);
		bus_wr(OFF_CORE_CTRL, cw(3'h1, MODE_COUNTER, 1'b1, 1'b0));
		pc.drive(1'b1);
		rd_chk(OFF_CORE_VAL, 16'h1279);
		$display("test software latch done");
		complete_run();
	end
	// Watchdog against a hung handshake
	initial begin
		repeat (30000) @(posedge clk);
		bad_count++;
		complete_run();
	end
endmodule
